// File: core/cig_pkg.sv
// types shared by the idle/gating block
package cig_pkg;

  typedef struct packed {
    logic fft;
    logic fetch;
    logic mem;
    logic io;
    logic data;
    logic core;
  } cig_idle_s;

endpackage

// File: core/cig_regs.svh
// register indices, field positions, reset values and timing counts for the idle/gating block
// Functional notes
// - An idle instruction with any port request and a setup field other than 0111 raises the bus error flag and changes nothing.
// - A valid idle instruction copies the idle configuration into the idle state register, which then drives the domain clocks.
// - With the core idled execution halts right after the idle instruction; without it only memory port or fft idle is taken, data/io/fetch raise bus error.
// - Any unmasked interrupt clears idle state bits 0, 5, 6 and 8, waking the core, data, io and fetch ports.
// - Once the core is woken by an interrupt, the interrupt is seen in the flag register 3 core cycles later.
// - Interrupts never wake the memory port or the fft accelerator; only software does.
// - A gated peripheral keeps its full state and resumes where it stopped when its clock returns.
// - A write to the peripheral clock gate register reaches the clocks within 6 system clock cycles, with no idle instruction.
// - A peripheral gate bit at zero keeps that clock running and at one stops it.
// - The system clock off bit stops the system clock only while the wake pin is low; the wake pin high restarts it.
`ifndef CIG_REGS_SVH
`define CIG_REGS_SVH

`define CIG_IDX_W 14
`define CIG_IDX_ICR 14'h0001
`define CIG_IDX_IDLE_STATE_REG 14'h0002
`define CIG_IDX_PCG1 14'h1c02
`define CIG_IDX_EVT 14'h1c40
`define CIG_IDX_EMSK 14'h1c41

`define CIG_CPU_BIT 0
`define CIG_CFG_LO 1
`define CIG_CFG_HI 4
`define CIG_DATA_PORT_BIT 5
`define CIG_IO_PORT_BIT 6
`define CIG_MEM_PORT_BIT 7
`define CIG_FETCH_PORT_BIT 8
`define CIG_HWA_BIT 9
`define CIG_CFG_OK 4'h7
`define CIG_ICR_WMASK 16'h03ff
`define CIG_SYSOFF_BIT 15

`define CIG_EV_BUS_ERROR_FLAG 0
`define CIG_EV_IDLE 1
`define CIG_EV_WAKE 2
`define CIG_EV_W 3

`define CIG_ICR_RST 16'h0000
`define CIG_PCG1_RST 16'h0000
`define CIG_EVT_RST 3'h0
`define CIG_EMSK_RST 3'h0

`define CIG_IRQ_DETECT_CYC 2'h3

`endif

// File: core/cig_top.sv
// cpu idle controller and peripheral clock gating behind a wishbone slave
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "cig_regs.svh"
module cig_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu core side
  input wire logic idle_exec_i,
  input wire logic unmasked_irq_i,
  output cig_pkg::cig_idle_s idle_o,
  output logic bus_error_flag_o,
  output logic irq_detect_o,
  // peripheral and system clocks
  input wire logic wake_pin_i,
  output logic [14:0] periph_gate_o,
  output logic system_clock_en_o,
  // interrupt
  output logic irq_o
);
  import cig_pkg::*;

  logic [`CIG_IDX_W-1:0] idx;
  logic req;
  logic wr_fire;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [15:0] rd_word;
  logic [15:0] icr_reg;
  cig_idle_s idle_state_reg_reg;
  cig_idle_s idle_state_reg_next;
  cig_idle_s icr_idle;
  logic [15:0] pcg_reg;
  logic [14:0] gate_reg;
  logic sys_en_reg;
  logic [`CIG_EV_W-1:0] evt_reg;
  logic [`CIG_EV_W-1:0] emsk_reg;
  logic [`CIG_EV_W-1:0] ev_set;
  logic [`CIG_EV_W-1:0] ev_clr;
  logic irq_reg;
  logic bus_error_flag_reg;
  logic det_reg;
  logic [1:0] det_cnt_reg;
  logic idle_ok;
  logic idle_take;
  logic wake_core;

  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic [15:0] nw,
                                             input logic [1:0] sel);
    byte_merge = old;
    if (sel[0]) byte_merge[7:0] = nw[7:0];
    if (sel[1]) byte_merge[15:8] = nw[15:8];
  endfunction

  function automatic logic idle_cfg_valid(input logic [15:0] c);
    logic port_req;
    logic dep_req;
    port_req = c[`CIG_DATA_PORT_BIT] | c[`CIG_IO_PORT_BIT] | c[`CIG_FETCH_PORT_BIT] | c[`CIG_MEM_PORT_BIT];
    dep_req = c[`CIG_DATA_PORT_BIT] | c[`CIG_IO_PORT_BIT] | c[`CIG_FETCH_PORT_BIT];
    idle_cfg_valid = !(port_req && (c[`CIG_CFG_HI:`CIG_CFG_LO] != `CIG_CFG_OK))
                     && !(dep_req && !c[`CIG_CPU_BIT]);
  endfunction

  function automatic cig_idle_s to_idle(input logic [15:0] c);
    to_idle.fft = c[`CIG_HWA_BIT];
    to_idle.fetch = c[`CIG_FETCH_PORT_BIT];
    to_idle.mem = c[`CIG_MEM_PORT_BIT];
    to_idle.io = c[`CIG_IO_PORT_BIT];
    to_idle.data = c[`CIG_DATA_PORT_BIT];
    to_idle.core = c[`CIG_CPU_BIT];
  endfunction

  function automatic logic [15:0] idle_word(input cig_idle_s s);
    idle_word = 16'h0000;
    idle_word[`CIG_HWA_BIT] = s.fft;
    idle_word[`CIG_FETCH_PORT_BIT] = s.fetch;
    idle_word[`CIG_MEM_PORT_BIT] = s.mem;
    idle_word[`CIG_IO_PORT_BIT] = s.io;
    idle_word[`CIG_DATA_PORT_BIT] = s.data;
    idle_word[`CIG_CPU_BIT] = s.core;
  endfunction

  // wishbone classic: ack one cycle after the strobe, write lands on the ack edge
  assign idx = wb_adr_i[15:2];
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_fire = req && wb_we_i && ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  // unmapped indices read zero and still ack, so a stray access never hangs the bus
  always_comb begin
    case (idx)
      `CIG_IDX_ICR: rd_word = icr_reg;
      `CIG_IDX_IDLE_STATE_REG: rd_word = idle_word(idle_state_reg_reg);
      `CIG_IDX_PCG1: rd_word = pcg_reg;
      `CIG_IDX_EVT: rd_word = {13'h0000, evt_reg};
      `CIG_IDX_EMSK: rd_word = {13'h0000, emsk_reg};
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg) begin
      dat_reg <= {16'h0000, rd_word};
    end
  end

  // idle configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      icr_reg <= `CIG_ICR_RST;
    end else if (wr_fire && idx == `CIG_IDX_ICR) begin
      icr_reg <= byte_merge(icr_reg, wb_dat_i[15:0], wb_sel_i[1:0]) & `CIG_ICR_WMASK;
    end
  end

  // idle instruction handling
  assign idle_ok = idle_cfg_valid(icr_reg);
  assign idle_take = idle_exec_i && idle_ok;
  assign icr_idle = to_idle(icr_reg);
  assign wake_core = unmasked_irq_i && idle_state_reg_reg.core;

  // interrupt wake is taken on the next edge; the core sees it on irq_detect_o three edges after that
  always_comb begin
    idle_state_reg_next = idle_state_reg_reg;
    if (idle_take) begin
      idle_state_reg_next = icr_idle;
    end
    if (unmasked_irq_i) begin
      idle_state_reg_next.core = 1'b0;
      idle_state_reg_next.data = 1'b0;
      idle_state_reg_next.io = 1'b0;
      idle_state_reg_next.fetch = 1'b0;
    end
    // memory port and accelerator keep their state here
  end

  // a rejected idle leaves idle_state_reg_next at its old value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_state_reg_reg <= '0;
    end else begin
      idle_state_reg_reg <= idle_state_reg_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_error_flag_reg <= 1'b0;
    end else begin
      bus_error_flag_reg <= idle_exec_i && !idle_ok;
    end
  end

  // interrupt detect delay after core wake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_cnt_reg <= 2'h0;
      det_reg <= 1'b0;
    end else begin
      det_reg <= (det_cnt_reg == 2'h1);
      if (wake_core) begin
        det_cnt_reg <= `CIG_IRQ_DETECT_CYC;
      end else if (det_cnt_reg != 2'h0) begin
        det_cnt_reg <= det_cnt_reg - 2'h1;
      end
    end
  end

  // peripheral clock gate register; wake pin overrides the system clock off bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcg_reg <= `CIG_PCG1_RST;
    end else begin
      if (wr_fire && idx == `CIG_IDX_PCG1) begin
        pcg_reg <= byte_merge(pcg_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wake_pin_i) begin
        pcg_reg[`CIG_SYSOFF_BIT] <= 1'b0;
      end
    end
  end

  // gates are enables only, peripherals are never reset by them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_reg <= 15'h0000;
      sys_en_reg <= 1'b1;
    end else begin
      gate_reg <= pcg_reg[14:0];
      sys_en_reg <= !(pcg_reg[`CIG_SYSOFF_BIT] && !wake_pin_i);
    end
  end

  // event status, write one to clear; a new event beats a clear
  assign ev_set = {wake_core, idle_take, idle_exec_i && !idle_ok};
  assign ev_clr = (wr_fire && idx == `CIG_IDX_EVT && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_reg <= `CIG_EVT_RST;
      emsk_reg <= `CIG_EMSK_RST;
      irq_reg <= 1'b0;
    end else begin
      evt_reg <= (evt_reg & ~ev_clr) | ev_set;
      if (wr_fire && idx == `CIG_IDX_EMSK && wb_sel_i[0]) begin
        emsk_reg <= wb_dat_i[2:0];
      end
      irq_reg <= |(evt_reg & emsk_reg);
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign idle_o = idle_state_reg_reg;
  assign bus_error_flag_o = bus_error_flag_reg;
  assign irq_detect_o = det_reg;
  assign periph_gate_o = gate_reg;
  assign system_clock_en_o = sys_en_reg;
  assign irq_o = irq_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_bad_cfg;
    idle_exec_i && (icr_reg[`CIG_MEM_PORT_BIT] || icr_reg[`CIG_DATA_PORT_BIT])
      && (icr_reg[`CIG_CFG_HI:`CIG_CFG_LO] != `CIG_CFG_OK) |=> bus_error_flag_o;
  endproperty
  a_bad_cfg: assert property (p_bad_cfg) else $error("bad setup field not flagged");

  property p_dep;
    idle_exec_i && (icr_reg[`CIG_IO_PORT_BIT] || icr_reg[`CIG_FETCH_PORT_BIT])
      && !icr_reg[`CIG_CPU_BIT] |=> bus_error_flag_o ##1 !bus_error_flag_o || idle_exec_i;
  endproperty
  a_dep: assert property (p_dep) else $error("port idle without core not flagged");

  property p_copy;
    idle_exec_i && idle_ok && !unmasked_irq_i |=> idle_o == $past(icr_idle) && !bus_error_flag_o;
  endproperty
  a_copy: assert property (p_copy) else $error("idle state not copied");

  property p_halt;
    idle_exec_i && idle_ok && icr_reg[`CIG_CPU_BIT] && !unmasked_irq_i |=> idle_o.core;
  endproperty
  a_halt: assert property (p_halt) else $error("core not halted after idle");

  property p_wake;
    unmasked_irq_i |=> !idle_o.core && !idle_o.data && !idle_o.io && !idle_o.fetch;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not wake domains");

  property p_detect;
    wake_core |=> !irq_detect_o [*3] ##1 irq_detect_o;
  endproperty
  a_detect: assert property (p_detect) else $error("interrupt detect not three cycles");

  property p_keep_mem;
    unmasked_irq_i && !idle_take |=> idle_o.mem == $past(idle_o.mem)
      && idle_o.fft == $past(idle_o.fft);
  endproperty
  a_keep_mem: assert property (p_keep_mem) else $error("memory port woken by irq");

  property p_reject;
    idle_exec_i && !idle_ok && !unmasked_irq_i |=> idle_o == $past(idle_o);
  endproperty
  a_reject: assert property (p_reject) else $error("rejected idle changed state");

  property p_gate_time;
    wr_fire && idx == `CIG_IDX_PCG1 |=> ##[0:5] periph_gate_o == pcg_reg[14:0];
  endproperty
  a_gate_time: assert property (p_gate_time) else $error("gate write too slow");

  property p_gate_map;
    ##1 1'b1 |-> periph_gate_o == $past(pcg_reg[14:0]);
  endproperty
  a_gate_map: assert property (p_gate_map) else $error("gate bit does not follow register");

  property p_system_clock_signal;
    (wake_pin_i |=> system_clock_en_o && !pcg_reg[`CIG_SYSOFF_BIT])
      and (pcg_reg[`CIG_SYSOFF_BIT] && !wake_pin_i |=> !system_clock_en_o);
  endproperty
  a_system_clock_signal: assert property (p_system_clock_signal) else $error("system clock off bit misbehaves");

  // bus, event, hold and pulse shape checks
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

  property p_bus_error_flag_only;
    !idle_exec_i |=> !bus_error_flag_o;
  endproperty
  a_bus_error_flag_only: assert property (p_bus_error_flag_only) else $error("stray bus error");

  property p_hold_idle;
    !idle_exec_i && !unmasked_irq_i |=> $stable(idle_o);
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("idle state moved");

  property p_irq_level;
    ##1 1'b1 |-> irq_o == $past(|(evt_reg & emsk_reg));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq does not follow events");

  property p_det_pulse;
    irq_detect_o |=> !irq_detect_o;
  endproperty
  a_det_pulse: assert property (p_det_pulse) else $error("detect pulse too long");

  property p_gate_hold;
    !(wr_fire && idx == `CIG_IDX_PCG1) && !wake_pin_i |=> $stable(pcg_reg);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate register moved");

  property p_evt_wake;
    wake_core |=> evt_reg[`CIG_EV_WAKE];
  endproperty
  a_evt_wake: assert property (p_evt_wake) else $error("wake event not recorded");

  c_idle_core: cover property (idle_take && icr_reg[`CIG_CPU_BIT] ##1 idle_o.core);
  c_reject: cover property (idle_exec_i && !idle_ok ##1 bus_error_flag_o);
  c_wake: cover property (wake_core ##4 irq_detect_o);
  c_system_clock_signal_on: cover property (!system_clock_en_o && wake_pin_i ##1 system_clock_en_o);
  c_gate: cover property (wr_fire && idx == `CIG_IDX_PCG1 && wb_dat_i[0] ##2 periph_gate_o[0]);

endmodule

// File: testbench/tb.sv
// self-checking bench for the idle controller and peripheral clock gates
`timescale 1ns/1ps
`include "cig_regs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  import cig_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic we = 0;
  logic idle = 0;
  logic irq = 0;
  logic wake = 0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, bus_error_flag, det, sys_en, irq_o;
  logic [14:0] gate;
  cig_idle_s idle_o;
  int fails = 0;
  int total_checks = 0;
  int cyc_cnt = 0;
  int n;
  logic [13:0] ri [6] = '{`CIG_IDX_ICR, `CIG_IDX_IDLE_STATE_REG, `CIG_IDX_PCG1, `CIG_IDX_EVT,
                          `CIG_IDX_EMSK, 14'h0100};
  logic [15:0] bad [4] = '{16'h0021, 16'h0081, 16'h002e, 16'h010e};

  cig_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_sel_i(4'h3), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .idle_exec_i(idle), .unmasked_irq_i(irq), .idle_o(idle_o),
    .bus_error_flag_o(bus_error_flag), .irq_detect_o(det), .wake_pin_i(wake),
    .periph_gate_o(gate), .system_clock_en_o(sys_en), .irq_o(irq_o));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // hang guard, far above the roughly two hundred cycles the tests need
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ack read right after the rising edge, as the design sampled it; write lands there
  task automatic bus(input logic w, input logic [13:0] idx, input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {16'h0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 16'h0000);
    `CHK("register read", e, rdat)
    @(negedge clk_i);
  endtask

  task automatic do_idle(input logic [15:0] cfg);
    bus(1'b1, `CIG_IDX_ICR, cfg);
    @(posedge clk_i);
    idle <= 1'b1;
    @(posedge clk_i);
    idle <= 1'b0;
    @(negedge clk_i);
  endtask

  // n counts edges from the wake edge to the detect pulse
  task automatic do_wake();
    @(posedge clk_i);
    irq <= 1'b1;
    @(posedge clk_i);
    irq <= 1'b0;
    n = 0;
    @(negedge clk_i);
    while (det !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("clock enable", 1'b1, sys_en)
    `CHK("gates", 15'h0000, gate)
    `CHK("idle state", 6'h00, idle_o)
    foreach (ri[i]) rd(ri[i], 32'h0000_0000);
    bus(1'b1, `CIG_IDX_ICR, 16'hffff);
    rd(`CIG_IDX_ICR, 32'h0000_03ff);
    bus(1'b1, 14'h0100, 16'h1234);
    rd(14'h0100, 32'h0000_0000);
    // rejected configurations leave the state alone
    foreach (bad[i]) begin
      do_idle(bad[i]);
      `CHK("bus error", 1'b1, bus_error_flag)
      `CHK("idle state", 6'h00, idle_o)
    end
    rd(`CIG_IDX_EVT, 32'h0000_0001);
    `CHK("masked irq", 1'b0, irq_o)
    bus(1'b1, `CIG_IDX_EMSK, 16'h0001);
    repeat (2) @(negedge clk_i);
    `CHK("irq", 1'b1, irq_o)
    bus(1'b1, `CIG_IDX_EVT, 16'h0001);
    repeat (2) @(negedge clk_i);
    `CHK("irq cleared", 1'b0, irq_o)
    // valid idle of core and all ports
    do_idle(16'h01ef);
    `CHK("bus error", 1'b0, bus_error_flag)
    `CHK("idle state", 6'h1f, idle_o)
    bus(1'b0, `CIG_IDX_IDLE_STATE_REG, 16'h0000);
    `CHK("status copy", 32'h0000_01e1, rdat)
    do_idle(16'h0021);
    `CHK("idle state", 6'h1f, idle_o)
    do_wake();
    `CHK("idle state", 6'h08, idle_o)
    `CHK("detect delay", 3, n)
    do_idle(16'h000e);
    `CHK("idle state", 6'h00, idle_o)
    do_idle(16'h020f);
    `CHK("idle state", 6'h21, idle_o)
    do_wake();
    `CHK("idle state", 6'h20, idle_o)
    rd(`CIG_IDX_EVT, 32'h0000_0007);
    `CHK("irq", 1'b1, irq_o)
    bus(1'b1, `CIG_IDX_EVT, 16'h0007);
    rd(`CIG_IDX_EVT, 32'h0000_0000);
    `CHK("irq cleared", 1'b0, irq_o)
    bus(1'b1, `CIG_IDX_EMSK, 16'h0004);
    do_idle(16'h000f);
    `CHK("idle state", 6'h01, idle_o)
    `CHK("masked irq", 1'b0, irq_o)
    do_wake();
    `CHK("idle state", 6'h00, idle_o)
    `CHK("wake irq", 1'b1, irq_o)
    // peripheral gates, counted from the ack edge
    // peripherals idle on the bus; stop permission taken as granted
    bus(1'b1, `CIG_IDX_PCG1, 16'h7fff);
    repeat (6) @(negedge clk_i);
    `CHK("gates", 15'h7fff, gate)
    `CHK("clock enable", 1'b1, sys_en)
    rd(`CIG_IDX_PCG1, 32'h0000_7fff);
    bus(1'b1, `CIG_IDX_PCG1, 16'h8000);
    repeat (6) @(negedge clk_i);
    `CHK("gates", 15'h0000, gate)
    `CHK("clock enable", 1'b0, sys_en)
    @(posedge clk_i);
    wake <= 1'b1;
    repeat (6) @(negedge clk_i);
    `CHK("clock enable", 1'b1, sys_en)
    rd(`CIG_IDX_PCG1, 32'h0000_0000);
    bus(1'b1, `CIG_IDX_PCG1, 16'h8000);
    repeat (6) @(negedge clk_i);
    `CHK("clock enable", 1'b1, sys_en)
    summarize();
  end
endmodule
